// [rtl/serial_register_port.sv]
// Function
// - Every mode register is read and written through this one serial port.
// - Bit 6 of interface_select_reg picks 4-wire (1) or 3-wire (0) operation.
// - In 3-wire mode serial_data_io carries write data in and read data out.
// - In 4-wire mode serial_data_io is input only, alarm_serial_out output.
// - Input bits are captured on rising edges of the serial clock.
// - Read-back bits change on falling edges of the serial clock.
// - The first byte of a frame is the instruction byte.
// - Bytes two to five carry the register data right after the instruction.
// - Instruction direction bit one means read, zero means write.
// - A two-bit byte_count_field gives the data byte count, sent MSB first.
// - A five-bit register_address_field is the start, decremented per byte.
// - 4-wire reads drive alarm_serial_out low after the last falling edge.
`timescale 1ns/1ps
`include "serial_register_port_defs.svh"

module serial_register_port
    import serial_register_port_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst_n,
    input  wire logic                     serial_clk,
    input  wire logic                     frame_enable_n,
    input  wire logic                     serial_data_in,
    output logic                          serial_data_out,
    output logic                          serial_data_oe,
    output logic                          alarm_serial_out,
    output logic                          alarm_serial_oe,
    output logic                          four_wire_select,
    output logic                          reg_wr_pulse,
    output logic [`SRP_ADDR_W-1:0]        reg_wr_addr,
    output logic [`SRP_DATA_W-1:0]        reg_wr_data
);

    // ==========================================================
    // helpers
    // data byte count from byte_count_field: 00 -> 1 ... 11 -> 4
    function automatic logic [2:0] bytes_of(input logic [1:0] count_field);
        bytes_of = {1'b0, count_field} + 3'h1;
    endfunction

    // ==========================================================
    // pin synchronisers
    logic                   sclk_s1;
    logic                   sclk_s2;
    logic                   sclk_s3;
    logic                   fen_s1;
    logic                   fen_s2;
    logic                   din_s1;
    logic                   din_s2;
    logic                   sclk_rise;
    logic                   sclk_fall;
    logic                   frame_on;

    // two flops per pin, third flop on the clock only for edge finding
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            fen_s1  <= 1'b1;
            fen_s2  <= 1'b1;
            din_s1  <= 1'b0;
            din_s2  <= 1'b0;
        end
        else
        begin
            sclk_s1 <= serial_clk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            fen_s1  <= frame_enable_n;
            fen_s2  <= fen_s1;
            din_s1  <= serial_data_in;
            din_s2  <= din_s1;
        end
    end

    // edges of the synchronised serial clock inside a frame
    assign frame_on  = ~fen_s2;
    assign sclk_rise = frame_on & sclk_s2 & ~sclk_s3;
    assign sclk_fall = frame_on & ~sclk_s2 & sclk_s3;

    // ==========================================================
    // frame decoder
    logic [2:0]             bit_cnt;
    logic [2:0]             bytes_left;
    logic [`SRP_ADDR_W-1:0] addr;
    logic [6:0]             shift_in;
    logic                   is_read;
    logic [7:0]             out_byte;
    phase_e                 phase;
    logic [7:0]             next_byte;
    logic                   byte_done;
    logic                   wr_fire;
    logic [`SRP_DATA_W-1:0] regs [`SRP_NUM_REGS];

    assign next_byte = {shift_in, din_s2};
    assign byte_done = sclk_rise & (bit_cnt == `SRP_LAST_BIT);
    assign wr_fire   = byte_done & (phase == PH_DATA) & ~is_read;

    // bit shifting and byte counting; bit_cnt, bytes_left and phase cleared between frames
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bit_cnt    <= 3'h0;
            bytes_left <= 3'h0;
            addr       <= '0;
            shift_in   <= 7'h00;
            is_read    <= 1'b0;
            out_byte   <= 8'h00;
            phase      <= PH_INSTR;
        end
        else if (!frame_on)
        begin
            bit_cnt    <= 3'h0;
            bytes_left <= 3'h0;
            phase      <= PH_INSTR;
        end
        else if (sclk_rise)
        begin
            shift_in <= next_byte[6:0];
            bit_cnt  <= bit_cnt + 3'h1;
            if (byte_done)
            begin
                case (phase)
                    PH_INSTR:
                    begin
                        is_read    <= next_byte[`SRP_RW_BIT];
                        bytes_left <= bytes_of(
                            next_byte[`SRP_CNT_MSB:`SRP_CNT_LSB]);
                        addr       <= next_byte[`SRP_ADDR_MSB:0];
                        out_byte   <= regs[next_byte[`SRP_ADDR_MSB:0]];
                        phase      <= PH_DATA;
                    end
                    PH_DATA:
                    begin
                        bytes_left <= bytes_left - 3'h1;
                        addr       <= addr - 5'h01;
                        out_byte   <= regs[addr - 5'h01];
                        if (bytes_left == 3'h1)
                            phase <= PH_DONE;
                    end
                    PH_DONE:
                        phase <= PH_DONE;  // extra bytes ignored
                    default:
                        phase <= PH_INSTR;
                endcase
            end
        end
    end

    // ==========================================================
    // register array
    // whole data byte committed at once, only after its eighth bit
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < `SRP_NUM_REGS; i++)
                regs[i] <= `SRP_REG_RESET;
        end
        else if (wr_fire)
        begin
            regs[addr] <= next_byte;
        end
    end

    // write notice towards the rest of the chip
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_wr_pulse <= 1'b0;
            reg_wr_addr  <= '0;
            reg_wr_data  <= '0;
        end
        else
        begin
            reg_wr_pulse <= wr_fire;
            if (wr_fire)
            begin
                reg_wr_addr <= addr;
                reg_wr_data <= next_byte;
            end
        end
    end

    // mode bit straight from the interface selection register
    assign four_wire_select =
        regs[`SRP_IFSEL_ADDR][`SRP_FOUR_WIRE_BIT];

    // ==========================================================
    // read-back drivers
    // bits move on falling edges; pins released when the frame ends
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_data_out  <= 1'b0;
            serial_data_oe   <= 1'b0;
            alarm_serial_out <= 1'b0;
            alarm_serial_oe  <= 1'b0;
        end
        else if (!frame_on)
        begin
            serial_data_oe   <= 1'b0;
            alarm_serial_oe  <= 1'b0;
            alarm_serial_out <= 1'b0;
        end
        else if (sclk_fall && is_read && phase == PH_DATA)
        begin
            if (four_wire_select)
            begin
                alarm_serial_out <= out_byte[~bit_cnt];
                alarm_serial_oe  <= 1'b1;
                serial_data_oe   <= 1'b0;
            end
            else
            begin
                serial_data_out <= out_byte[~bit_cnt];
                serial_data_oe  <= 1'b1;
                alarm_serial_oe <= 1'b0;
            end
        end
        else if (sclk_fall && is_read && phase == PH_DONE)
        begin
            serial_data_oe   <= 1'b0;
            alarm_serial_out <= 1'b0;
            alarm_serial_oe  <= four_wire_select;
        end
    end

endmodule // serial_register_port

// [rtl/serial_register_port_defs.svh]
`ifndef SERIAL_REGISTER_PORT_DEFS_SVH
`define SERIAL_REGISTER_PORT_DEFS_SVH

// ==========================================================
// register space
`define SRP_ADDR_W        5
`define SRP_DATA_W        8
`define SRP_NUM_REGS      32
`define SRP_REG_RESET     8'h00
`define SRP_IFSEL_ADDR    5'h03
`define SRP_FOUR_WIRE_BIT 6

// ==========================================================
// instruction byte layout
`define SRP_RW_BIT        7
`define SRP_CNT_MSB       6
`define SRP_CNT_LSB       5
`define SRP_ADDR_MSB      4
`define SRP_LAST_BIT      3'h7

`endif

// [rtl/serial_register_port_pkg.sv]
package serial_register_port_pkg;

    // frame phase: instruction byte, data bytes, finished
    typedef enum logic [1:0] {
        PH_INSTR,
        PH_DATA,
        PH_DONE
    } phase_e;

endpackage

// [dv/serial_register_port_asserts.sv]
`timescale 1ns/1ps
`include "serial_register_port_defs.svh"
module serial_register_port_asserts (
    input wire logic                   sys_clk,
    input wire logic                   rst_n,
    input wire logic                   serial_clk,
    input wire logic                   frame_enable_n,
    input wire logic                   serial_data_in,
    input wire logic                   serial_data_out,
    input wire logic                   serial_data_oe,
    input wire logic                   alarm_serial_out,
    input wire logic                   alarm_serial_oe,
    input wire logic                   four_wire_select,
    input wire logic                   reg_wr_pulse,
    input wire logic [`SRP_ADDR_W-1:0] reg_wr_addr,
    input wire logic [`SRP_DATA_W-1:0] reg_wr_data
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================================
    // pin direction and timing
    AST_OE_EXCL:
        assert property (!(serial_data_oe && alarm_serial_oe))
        else $error("oe clash");
    AST_SDO_MODE:
        assert property (serial_data_oe |-> !four_wire_select)
        else $error("sdo mode");
    AST_ALARM_MODE:
        assert property (alarm_serial_oe |-> four_wire_select)
        else $error("alarm mode");
    AST_ALARM_REL:
        assert property ($rose(frame_enable_n) |-> ##[1:5] !alarm_serial_oe)
        else $error("alarm held");
    AST_IDLE:
        assert property (frame_enable_n [*5]
                         |-> !serial_data_oe && !alarm_serial_oe)
        else $error("idle drive");
    AST_PULSE_ONE:
        assert property (reg_wr_pulse |=> !reg_wr_pulse)
        else $error("long pulse");
    AST_WR_HOLD:
        assert property ($changed(reg_wr_addr) || $changed(reg_wr_data)
                         |-> reg_wr_pulse)
        else $error("write moved");
    AST_SDO_FALL:
        assert property ($changed(serial_data_out) && serial_data_oe
                         |-> !$past(serial_clk))
        else $error("sdo edge");
    AST_PULSE_RISE:
        assert property (reg_wr_pulse |-> $past(serial_clk, 2))
        else $error("pulse edge");
endmodule // serial_register_port_asserts

bind serial_register_port serial_register_port_asserts chk (
    .sys_clk, .rst_n, .serial_clk, .frame_enable_n, .serial_data_in,
    .serial_data_out, .serial_data_oe, .alarm_serial_out, .alarm_serial_oe,
    .four_wire_select, .reg_wr_pulse, .reg_wr_addr, .reg_wr_data
);

// [dv/serial_host_model.sv]
`timescale 1ns/1ps
module serial_host_model (
    input  wire logic sys_clk,
    input  wire logic fw,
    input  wire logic sdo_wire,
    input  wire logic alarm_line,
    output logic      serial_clk,
    output logic      frame_enable_n,
    output logic      host_data
);
    // idle: clock low, frame closed
    initial
    begin
        serial_clk = 1'b0;
        frame_enable_n = 1'b1;
        host_data = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // one frame: instruction then nb data bits, msb first
    task automatic xfer(input logic [7:0] ins, input logic [31:0] wd,
                        input int nb, output logic [31:0] rd);
        logic [39:0] frame_bits;
        frame_bits = {ins, wd};
        rd = '0;
        frame_enable_n = 1'b0;
        tick(4);
        for (int i = 0; i < 8 + nb; i++)
        begin
            if (i < 8 || !ins[7])
                host_data = frame_bits[39-i];
            else
                host_data = ~host_data;
            tick(4);
            if (i >= 8)
                rd = {rd[30:0], fw ? alarm_line : sdo_wire};
            serial_clk = 1'b1;
            tick(4);
            serial_clk = 1'b0;
        end
        tick(6);
    endtask
    task automatic stop();
        frame_enable_n = 1;
        tick(8);
    endtask
endmodule // serial_host_model

// [dv/serial_register_port_test.sv]
`timescale 1ns/1ps
`include "serial_register_port_defs.svh"
module serial_register_port_test;
    logic                   sys_clk, rst_n, serial_clk, frame_enable_n;
    logic                   host_data, serial_data_out, serial_data_oe;
    logic                   alarm_serial_out, alarm_serial_oe;
    logic                   four_wire_select, reg_wr_pulse;
    logic [`SRP_ADDR_W-1:0] reg_wr_addr;
    logic [`SRP_DATA_W-1:0] reg_wr_data;
    logic [31:0]            rd;
    int                     failures, total_checks, pulses, cycles;
    wire logic serial_data_in = serial_data_oe ? serial_data_out : host_data;
    // a floating alarm pin reads high, so only a driven low reads as zero
    wire logic alarm_line = alarm_serial_oe ? alarm_serial_out : 1'b1;
    serial_register_port uut (.sys_clk, .rst_n, .serial_clk, .frame_enable_n,
        .serial_data_in, .serial_data_out, .serial_data_oe, .alarm_serial_out,
        .alarm_serial_oe, .four_wire_select, .reg_wr_pulse, .reg_wr_addr,
        .reg_wr_data);
    serial_host_model host (.sys_clk, .fw(four_wire_select),
        .sdo_wire(serial_data_in), .alarm_line(alarm_line),
        .serial_clk, .frame_enable_n, .host_data);
    // clock
    initial
    begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // count write pulses, cut a hang short
    always @(posedge sys_clk)
    begin
        if (reg_wr_pulse === 1'b1) pulses++;
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // 3-wire four-byte write then read back, address wraps
    task automatic wr_rd_3wire();
        host.xfer(8'h61, 32'hA1B2C3D4, 32, rd);
        host.stop();
        chk("pulses", 4, pulses);
        chk("last addr", 5'h1E, reg_wr_addr);
        chk("last data", 8'hD4, reg_wr_data);
        host.xfer(8'hE1, 0, 32, rd);
        chk("sdo released", 0, serial_data_oe);
        host.stop();
        chk("read 3w", 32'hA1B2C3D4, rd);
    endtask
    // two-byte write with a surplus byte, then three-byte read back
    task automatic byte_counts();
        int p;
        p = pulses;
        host.xfer(8'h28, 32'h11223344, 24, rd);
        host.stop();
        chk("count 2", p + 2, pulses);
        chk("skip addr", 5'h07, reg_wr_addr);
        chk("skip data", 8'h22, reg_wr_data);
        host.xfer(8'hC8, 0, 24, rd);
        host.stop();
        chk("read 3", 32'h00112200, rd);
    endtask
    // switch to 4-wire and read on the alarm pin
    task automatic four_wire();
        host.xfer(8'h03, 32'h40000000, 8, rd);
        host.stop();
        chk("mode", 1, four_wire_select);
        host.xfer(8'h83, 0, 8, rd);
        chk("tail", 2'b01, {alarm_serial_out, alarm_serial_oe});
        host.stop();
        chk("read 4w", 8'h40, rd);
        chk("released", 0, alarm_serial_oe);
    endtask
    // frame cut short in mid byte commits nothing
    task automatic abort();
        int p;
        p = pulses;
        host.xfer(8'h05, 32'hFF000000, 5, rd);
        host.stop();
        chk("partial", p, pulses);
        host.xfer(8'h85, 0, 8, rd);
        host.stop();
        chk("kept", 0, rd);
    endtask
    // reset, then scenarios
    initial
    begin
        rst_n = 0;
        repeat (4) @(posedge sys_clk);
        #2 rst_n = 1;
        host.tick(4);
        chk("reset mode", 0, four_wire_select);
        wr_rd_3wire();
        byte_counts();
        four_wire();
        abort();
        report_and_stop();
    end
endmodule // serial_register_port_test
